//--- hdl/rsp_map.svh
// select codes, field positions and timing counts of the serial port and clock output
`ifndef RSP_MAP_SVH
`define RSP_MAP_SVH
`define RSP_CMD_BITS 8
`define RSP_CMD_READ_BIT 7
`define RSP_REF_HZ 32768
`define RSP_CLK_HZ 125000000
// half periods of the square wave in system clock cycles, rounded down
`define RSP_HALF_32K ((`RSP_CLK_HZ / `RSP_REF_HZ) / 2)
`define RSP_HALF_1K ((`RSP_CLK_HZ / 1024) / 2)
`define RSP_HALF_1HZ (`RSP_CLK_HZ / 2)
`define RSP_SEL_32K 2'h0
`define RSP_SEL_1K 2'h1
`define RSP_SEL_1HZ 2'h2
`define RSP_SEL_32K_B 2'h3
`endif

//--- hdl/rsp_pkg.sv
// types shared by the serial port block
package rsp_pkg;
   typedef enum logic [2:0] {
      RSP_IDLE = 3'h1,
      RSP_CMD = 3'h2,
      RSP_DATA = 3'h4
   } rsp_state_e;
   typedef struct packed {
      logic dir_read;
      logic [7:0] cmd;
   } rsp_cmd_s;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } rsp_byte_s;
endpackage

//--- hdl/rsp_serial_port.sv
// serial port, square wave output and interrupt pin of the clock module
`timescale 1ns/1ps
`include "rsp_map.svh"
module rsp_serial_port
   import rsp_pkg::*;
#(
   parameter int HALF_1HZ = `RSP_HALF_1HZ
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_select,
   input wire logic shift_clk,
   input wire logic serial_data_io_i,
   output logic serial_data_io_o,
   output logic serial_data_io_oe_n,
   input wire logic square_wave_out_enable,
   input wire logic wave_freq_select_hi,
   input wire logic wave_freq_select_lo,
   output logic square_wave_out,
   output logic square_wave_out_oe_n,
   input wire logic irq_event,
   output logic irq_n,
   output rsp_cmd_s cmd_out,
   output rsp_byte_s wr_byte,
   input wire logic [7:0] rd_data,
   output logic rd_next
);
   // ==========================================================
   // input synchronisers
   logic [1:0] cs_sync_ff, sck_sync_ff, dio_sync_ff, foe_sync_ff;
   logic cs_d_ff, sck_d_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_sync_ff <= 2'h0;
         sck_sync_ff <= 2'h0;
         dio_sync_ff <= 2'h0;
         foe_sync_ff <= 2'h0;
         cs_d_ff <= 1'b0;
         sck_d_ff <= 1'b0;
      end else begin
         cs_sync_ff <= {cs_sync_ff[0], chip_select};
         sck_sync_ff <= {sck_sync_ff[0], shift_clk};
         dio_sync_ff <= {dio_sync_ff[0], serial_data_io_i};
         foe_sync_ff <= {foe_sync_ff[0], square_wave_out_enable};
         cs_d_ff <= cs_sync_ff[1];
         sck_d_ff <= sck_sync_ff[1];
      end
   end
   wire cs_lvl = cs_sync_ff[1];
   wire cs_rise = cs_lvl & ~cs_d_ff;
   wire sck_rise = sck_sync_ff[1] & ~sck_d_ff;
   wire sck_fall = ~sck_sync_ff[1] & sck_d_ff;
   wire din = dio_sync_ff[1];

   // ==========================================================
   // serial transfer engine
   rsp_state_e state_ff, nxt_state;
   logic [7:0] shreg_ff, nxt_shreg;
   logic [2:0] bitcnt_ff, nxt_bitcnt;
   logic dir_read_ff, nxt_dir_read;
   logic [7:0] cmd_ff, nxt_cmd;
   logic wr_valid_ff, nxt_wr_valid;
   logic [7:0] wr_data_ff, nxt_wr_data;
   logic dout_ff, nxt_dout;
   logic drive_ff, nxt_drive;
   logic nxt_rd_next;
   wire last_bit = (bitcnt_ff == 3'h7);
   wire [7:0] shifted_in = {shreg_ff[6:0], din};
   always_comb begin
      nxt_state = state_ff;
      nxt_shreg = shreg_ff;
      nxt_bitcnt = bitcnt_ff;
      nxt_dir_read = dir_read_ff;
      nxt_cmd = cmd_ff;
      nxt_wr_valid = 1'b0;
      nxt_wr_data = wr_data_ff;
      nxt_dout = dout_ff;
      nxt_drive = drive_ff;
      nxt_rd_next = 1'b0;
      if (!cs_lvl) begin
         nxt_state = RSP_IDLE;
         nxt_drive = 1'b0;
         nxt_bitcnt = 3'h0;
      end else begin
         unique case (state_ff)
            RSP_IDLE: begin
               if (cs_rise) begin
                  nxt_state = RSP_CMD;
                  nxt_bitcnt = 3'h0;
               end
            end
            RSP_CMD: begin
               if (sck_rise) begin
                  nxt_shreg = shifted_in;
                  nxt_bitcnt = bitcnt_ff + 3'h1;
                  if (last_bit) begin
                     nxt_cmd = shifted_in;
                     nxt_dir_read = shifted_in[`RSP_CMD_READ_BIT];
                     nxt_state = RSP_DATA;
                     nxt_shreg = rd_data;
                  end
               end
            end
            RSP_DATA: begin
               if (dir_read_ff) begin
                  if (sck_fall) begin
                     nxt_drive = 1'b1;
                     nxt_dout = shreg_ff[7];
                     nxt_shreg = {shreg_ff[6:0], 1'b0};
                     nxt_bitcnt = bitcnt_ff + 3'h1;
                     if (last_bit) begin
                        nxt_shreg = rd_data;
                        nxt_rd_next = 1'b1;
                     end
                  end
               end else if (sck_rise) begin
                  nxt_shreg = shifted_in;
                  nxt_bitcnt = bitcnt_ff + 3'h1;
                  if (last_bit) begin
                     nxt_wr_valid = 1'b1;
                     nxt_wr_data = shifted_in;
                  end
               end
            end
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= RSP_IDLE;
         shreg_ff <= 8'h00;
         bitcnt_ff <= 3'h0;
         dir_read_ff <= 1'b0;
         cmd_ff <= 8'h00;
         wr_valid_ff <= 1'b0;
         wr_data_ff <= 8'h00;
         dout_ff <= 1'b0;
         drive_ff <= 1'b0;
         rd_next <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         shreg_ff <= nxt_shreg;
         bitcnt_ff <= nxt_bitcnt;
         dir_read_ff <= nxt_dir_read;
         cmd_ff <= nxt_cmd;
         wr_valid_ff <= nxt_wr_valid;
         wr_data_ff <= nxt_wr_data;
         dout_ff <= nxt_dout;
         drive_ff <= nxt_drive;
         rd_next <= nxt_rd_next;
      end
   end
   assign serial_data_io_o = dout_ff;
   assign serial_data_io_oe_n = ~(drive_ff & cs_lvl);
   assign cmd_out = '{dir_read: dir_read_ff, cmd: cmd_ff};
   assign wr_byte = '{valid: wr_valid_ff, data: wr_data_ff};

   // ==========================================================
   // square wave output
   logic [31:0] wcnt_ff, nxt_wcnt;
   logic wave_ff, nxt_wave;
   logic [31:0] half_sel;
   wire [1:0] fsel = {wave_freq_select_hi, wave_freq_select_lo};
   always_comb begin
      unique case (fsel)
         `RSP_SEL_1K: half_sel = 32'(`RSP_HALF_1K);
         `RSP_SEL_1HZ: half_sel = 32'(HALF_1HZ);
         `RSP_SEL_32K, `RSP_SEL_32K_B: half_sel = 32'(`RSP_HALF_32K);
      endcase
   end
   always_comb begin
      nxt_wcnt = wcnt_ff + 32'h1;
      nxt_wave = wave_ff;
      if (!foe_sync_ff[1]) begin
         nxt_wcnt = 32'h0;
         nxt_wave = 1'b0;
      end else if (nxt_wcnt >= half_sel) begin
         nxt_wcnt = 32'h0;
         nxt_wave = ~wave_ff;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wcnt_ff <= 32'h0;
         wave_ff <= 1'b0;
      end else begin
         wcnt_ff <= nxt_wcnt;
         wave_ff <= nxt_wave;
      end
   end
   assign square_wave_out = wave_ff;
   assign square_wave_out_oe_n = ~foe_sync_ff[1];

   // ==========================================================
   // interrupt pin, active low: registered inverse of irq_event, driven both high and low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_n <= 1'b1;
      end else begin
         irq_n <= ~irq_event;
      end
   end
endmodule

//--- sim/rsp_host_model.sv
// host model driving the three-wire link
`timescale 1ns/1ps
module rsp_host_model (
   input wire logic clk,
   output logic chip_select,
   output logic shift_clk,
   output logic serial_data_io_i,
   input wire logic serial_data_io_o,
   input wire logic serial_data_io_oe_n
);
   logic drv = 1'b0;
   logic bit_v = 1'b0;
   // an undriven line shows the inverse of its last level
   assign serial_data_io_i = !serial_data_io_oe_n ? serial_data_io_o : (drv ? bit_v : !bit_v);
   initial begin
      chip_select = 1'b0;
      shift_clk = 1'b0;
   end
   task automatic xfer(input logic [15:0] bits, input int n, output logic [7:0] rd);
      rd = 8'h00;
      chip_select <= 1'b1;
      repeat (10) @(posedge clk);
      for (int i = 0; i < n; i++) begin
         drv <= (i < 8) || !bits[15];
         bit_v <= bits[15 - i];
         repeat (10) @(posedge clk);
         shift_clk <= 1'b1;
         @(posedge clk);
         rd = {rd[6:0], serial_data_io_i};
         repeat (9) @(posedge clk);
         shift_clk <= 1'b0;
      end
      repeat (10) @(posedge clk);
      chip_select <= 1'b0;
      drv <= 1'b0;
      repeat (10) @(posedge clk);
   endtask
endmodule

//--- sim/rsp_serial_port_sva.sv
// checker of the serial port block
`timescale 1ns/1ps
module rsp_chk
   import rsp_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic chip_select,
   input wire logic shift_clk,
   input wire logic serial_data_io_o,
   input wire logic serial_data_io_oe_n,
   input wire logic square_wave_out_enable,
   input wire logic square_wave_out,
   input wire logic square_wave_out_oe_n,
   input wire logic irq_event,
   input wire logic irq_n,
   input wire rsp_cmd_s cmd_out,
   input wire rsp_byte_s wr_byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_cs_low_release: assert property (!chip_select [*4] |-> serial_data_io_oe_n) else $error("cs drive");
   a_wr_on_rise: assert property (wr_byte.valid |-> shift_clk) else $error("wr edge");
   a_wr_one_pulse: assert property (wr_byte.valid |=> !wr_byte.valid) else $error("wr pulse");
   // a new read bit shows three sampled edges after the pin fall
   a_rd_on_fall: assert property ($changed(serial_data_io_o) |-> !$past(shift_clk, 3)) else $error("rd edge");
   a_dir_match: assert property (wr_byte.valid |-> !cmd_out.dir_read && !cmd_out.cmd[7]) else $error("dir bit");
   a_drive_read: assert property (!serial_data_io_oe_n |-> cmd_out.dir_read) else $error("dir pin");
   a_wave_on: assert property (square_wave_out_enable [*5] |-> !square_wave_out_oe_n) else $error("wave on");
   a_wave_off: assert property (!square_wave_out_enable [*5] |-> square_wave_out_oe_n && !square_wave_out)
      else $error("wave off");
   a_irq_low: assert property (irq_event |=> !irq_n) else $error("irq low");
   a_irq_free: assert property (!irq_event |=> irq_n) else $error("irq free");
   c_write: cover property (wr_byte.valid);
   c_read: cover property ($fell(serial_data_io_oe_n));
   c_wave: cover property ($rose(square_wave_out));
endmodule
bind rsp_serial_port rsp_chk u_chk (.clk(clk), .resetn(resetn), .chip_select(chip_select), .shift_clk(shift_clk),
   .serial_data_io_o(serial_data_io_o), .serial_data_io_oe_n(serial_data_io_oe_n),
   .square_wave_out_enable(square_wave_out_enable), .square_wave_out(square_wave_out),
   .square_wave_out_oe_n(square_wave_out_oe_n), .irq_event(irq_event), .irq_n(irq_n), .cmd_out(cmd_out),
   .wr_byte(wr_byte));

//--- sim/rsp_serial_port_test.sv
// testbench of the serial port block
`timescale 1ns/1ps
module rsp_serial_port_test;
   import rsp_pkg::*;
   logic clk, resetn, cs, sck, din, dout, doe_n, wave, woe_n, irq_n, rd_next;
   logic wen = 1'b0;
   logic fhi = 1'b0;
   logic flo = 1'b0;
   logic irq_ev = 1'b0;
   rsp_cmd_s cmd_out;
   rsp_byte_s wr_byte;
   logic [7:0] rd, wr_seen;
   int err_count = 0;
   int compares = 0;
   int n_wr = 0;
   int n_rd = 0;
   rsp_serial_port #(.HALF_1HZ(100)) u_dut (.clk(clk), .resetn(resetn), .chip_select(cs), .shift_clk(sck),
      .serial_data_io_i(din), .serial_data_io_o(dout), .serial_data_io_oe_n(doe_n), .square_wave_out_enable(wen),
      .wave_freq_select_hi(fhi), .wave_freq_select_lo(flo), .square_wave_out(wave), .square_wave_out_oe_n(woe_n),
      .irq_event(irq_ev), .irq_n(irq_n), .cmd_out(cmd_out), .wr_byte(wr_byte), .rd_data(8'hA5), .rd_next(rd_next));
   rsp_host_model u_host (.clk(clk), .chip_select(cs), .shift_clk(sck), .serial_data_io_i(din),
      .serial_data_io_o(dout), .serial_data_io_oe_n(doe_n));
   always @(posedge clk) begin
      if (wr_byte.valid === 1'b1) begin
         n_wr <= n_wr + 1;
         wr_seen <= wr_byte.data;
      end
      if (rd_next === 1'b1) begin
         n_rd <= n_rd + 1;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic t_write(input logic [7:0] c, input logic [7:0] d);
      int n0;
      n0 = n_wr;
      u_host.xfer({c, d}, 16, rd);
      chk(cmd_out, {1'b0, c});
      chk(n_wr - n0, 1);
      chk(wr_seen, d);
   endtask
   task automatic t_read();
      int n0;
      n0 = n_rd;
      u_host.xfer(16'h8300, 16, rd);
      chk(cmd_out, 9'h183);
      chk(rd, 8'hA5);
      chk(n_rd - n0, 1);
   endtask
   task automatic t_abort();
      int n0;
      int n1;
      n0 = n_wr;
      u_host.xfer(16'h0155, 12, rd);
      chk(n_wr - n0, 0);
      n1 = n_rd;
      u_host.xfer(16'h8000, 12, rd);
      chk(doe_n, 1'b1);
      chk(n_rd - n1, 0);
   endtask
   task automatic t_wave(input logic [1:0] sel, input int half);
      int n;
      fhi <= sel[1];
      flo <= sel[0];
      wen <= 1'b1;
      // counter starts from zero two edges after enable, first rise after one half period
      n = 0;
      while (wave !== 1'b1 && n < half + 100) begin
         @(negedge clk);
         n++;
      end
      chk(n, half + 3);
      chk(woe_n, 1'b0);
      // a full half period is measured only where it fits the run length
      if (half < 4000) begin
         n = 0;
         while (wave === 1'b1 && n < half + 100) begin
            @(negedge clk);
            n++;
         end
         chk(n, half);
      end
      @(posedge clk);
      wen <= 1'b0;
      repeat (8) @(posedge clk);
      chk({woe_n, wave}, 2'h2);
   endtask
   task automatic t_irq();
      irq_ev <= 1'b1;
      repeat (2) @(posedge clk);
      chk(irq_n, 1'b0);
      irq_ev <= 1'b0;
      repeat (2) @(posedge clk);
      chk(irq_n, 1'b1);
   endtask
   task automatic print_verdict();
      $display("errors=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      t_write(8'h12, 8'hC3);
      t_read();
      t_abort();
      t_write(8'h7F, 8'h3C);
      t_wave(2'h0, 1907);
      t_wave(2'h3, 1907);
      t_wave(2'h2, 100);
      t_wave(2'h1, 61035);
      t_irq();
      print_verdict();
   end
endmodule
